/* File: design/pll_gate.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Per-PLL power-down: outputs low first, then power off
// -----------------------------------------------------------------
module pll_gate #(
   parameter int N = 2
) (
   input wire logic clk,
   input wire logic rst,
   pll_pwr_if.pll pif
);
   logic [N-1:0] low_s; // Synchronised outputs-low flags

   sync2 #(.W(N)) u_low (
      .clk(clk),
      .rst(rst),
      .d(pif.outs_low),
      .q(low_s)
   );

   for (genvar i = 0; i < N; i++) begin : g_pll
      logic gate_ff; // Clock outputs forced low
      logic pwr_ff;  // Supply on

      // Gate rises on request, drops only once powered again
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            gate_ff <= 1'b1;
         end else if (pif.off_req[i]) begin
            gate_ff <= 1'b1;
         end else if (pwr_ff) begin
            gate_ff <= 1'b0;
         end
      end

      // Power off only after every output seen low
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            pwr_ff <= 1'b0;
         end else if (!pif.off_req[i]) begin
            pwr_ff <= 1'b1;
         end else if (gate_ff && low_s[i]) begin
            pwr_ff <= 1'b0;
         end
      end

      assign pif.gate[i] = gate_ff;
      assign pif.pwr_en[i] = pwr_ff;

      property p_pll_low_first;
         @(posedge clk) disable iff (rst)
         $fell(pwr_ff) |-> $past(gate_ff) && $past(low_s[i]);
      endproperty
      a_pll_low_first: assert property (p_pll_low_first)
         else $error("PLL powered off before outputs were low");
   end
endmodule

/* File: design/pll_pwr_if.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// PLL power handshake between sequencer and PLL gate
// -----------------------------------------------------------------
interface pll_pwr_if #(parameter int N = 2);
   logic [N-1:0] off_req;  // Power-down wanted
   logic [N-1:0] outs_low; // Raw: all PLL outputs low
   logic [N-1:0] pwr_en;   // PLL powered
   logic [N-1:0] gate;     // Force PLL outputs low
   modport ctl (output off_req, output outs_low, input pwr_en, input gate);
   modport pll (input off_req, input outs_low, output pwr_en, output gate);
endinterface

/* File: design/pwr_pkg.sv */
package pwr_pkg;
   // -----------------------------------------------------------------
   // Bus geometry
   // -----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;
   // Word indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_PLL = 4'h1;
   localparam logic [3:0] IDX_BANK = 4'h2;
   localparam logic [3:0] IDX_PCLK = 4'h3;
   localparam logic [3:0] IDX_GUARD = 4'h4;
   localparam logic [3:0] IDX_STATUS = 4'h5;
   // -----------------------------------------------------------------
   // Control register fields
   // -----------------------------------------------------------------
   localparam int CTRL_BG_STBY = 0;   // Bandgap off in standby
   localparam int CTRL_POR_STBY = 1;  // Supply monitor off in standby
   localparam int CTRL_OSC_OFF = 2;   // Oscillator static disable
   localparam int CTRL_OSC_STBY = 3;  // Oscillator off in standby
   localparam int CTRL_MON_EN = 4;    // User-mode brown-out monitoring
   localparam int PLL_STBY_POS = 8;   // Standby-off field of PLL reg
   localparam int GUARD_STBY_POS = 16; // Standby-off field of guard reg
   localparam int MAX_PLL = 8;
   localparam int MAX_BANK = 6;
   localparam int BANKS_LARGE = 6;
   localparam int BANKS_SMALL = 4;
   // -----------------------------------------------------------------
   // Reset values and writable masks
   // -----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0010;
   localparam logic [31:0] PLL_RST = 32'h0000_0000;
   localparam logic [31:0] BANK_RST = 32'h0000_0000;
   localparam logic [31:0] PCLK_RST = 32'h0000_0000;
   localparam logic [31:0] GUARD_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h0000_001F;
   localparam logic [31:0] PLL_MASK = 32'h0000_FFFF;
   localparam logic [31:0] BANK_MASK = 32'h0000_003F;
   localparam logic [31:0] PCLK_MASK = 32'hFFFF_FFFF;
   localparam logic [31:0] GUARD_MASK = 32'hFFFF_FFFF;
   // -----------------------------------------------------------------
   // Reset sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {POR_HOLD, POR_WAIT, POR_LOAD, POR_USER} por_state_t;
endpackage

/* File: design/standby_power_and_por_control.sv */
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module standby_power_and_por_control
   import pwr_pkg::*;
#(
   parameter bit LARGE_DENSITY = 1'b1,
   parameter bit CORE_1V2 = 1'b1,
   parameter bit HAS_REGULATOR = 1'b0,
   parameter int NUM_PLL = 2,
   parameter int NUM_PCLK = 8,
   parameter int NUM_INBUF = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [pwr_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pwr_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [pwr_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic standby_req,
   input wire logic core_supply_ok,
   input wire logic config_bank_supply_ok,
   input wire logic ext_supply_ok,
   input wire logic brownout_bg_ok,
   input wire logic brownout_cell_ok,
   input wire logic limited_detect_ok,
   input wire logic config_done,
   input wire logic [NUM_PLL-1:0] pll_outs_low,
   output logic [NUM_PLL-1:0] pll_pwr_en,
   output logic [NUM_PLL-1:0] pll_out_gate,
   output logic bandgap_en,
   output logic por_monitor_en,
   output logic limited_detect_en,
   output logic osc_en,
   output logic brownout_sel_bandgap,
   output logic [pwr_pkg::MAX_BANK-1:0] bank_refdiff_en,
   output logic [NUM_PCLK-1:0] pclk_en,
   output logic [NUM_INBUF-1:0] inbuf_en,
   output logic io_tristate,
   output logic config_start,
   output logic device_reset
);
   import pwr_pkg::*;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [7:0] pins_s; // Synchronised pin levels
   logic standby_s, core_s, cfgbank_s, ext_s;
   logic bg_ok_s, cell_ok_s, limited_s, done_s;

   sync2 #(.W(8)) u_pins (
      .clk(clk),
      .rst(rst),
      .d({standby_req, core_supply_ok, config_bank_supply_ok, ext_supply_ok,
          brownout_bg_ok, brownout_cell_ok, limited_detect_ok, config_done}),
      .q(pins_s)
   );
   assign {standby_s, core_s, cfgbank_s, ext_s, bg_ok_s, cell_ok_s, limited_s, done_s} = pins_s;

   // -----------------------------------------------------------------
   // Register file over Avalon-MM
   // -----------------------------------------------------------------
   logic [31:0] ctrl_ff, pll_ff, bank_ff, pclk_ff, guard_ff;
   logic ack_ff;        // Second cycle of an access
   logic [31:0] rdata_ff; // Registered read data
   logic [31:0] status;   // Live state for software
   logic req;             // Access in progress
   logic wr_take;         // Write commits this edge

   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   assign req = avs_read || avs_write;
   // One wait state on every access
   assign avs_waitrequest = req && !ack_ff;
   assign wr_take = avs_write && ack_ff;
   assign avs_readdata = rdata_ff;

   // Wait-state toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req && !ack_ff;
      end
   end

   // Read mux, captured in the wait cycle; unmapped reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
      end else if (avs_read && !ack_ff) begin
         case (avs_address)
            IDX_CTRL: rdata_ff <= ctrl_ff;
            IDX_PLL: rdata_ff <= pll_ff;
            IDX_BANK: rdata_ff <= bank_ff;
            IDX_PCLK: rdata_ff <= pclk_ff;
            IDX_GUARD: rdata_ff <= guard_ff;
            IDX_STATUS: rdata_ff <= status;
            default: rdata_ff <= '0;
         endcase
      end
   end

   // Writable registers; status and unmapped ignore writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= CTRL_RST;
         pll_ff <= PLL_RST;
         bank_ff <= BANK_RST;
         pclk_ff <= PCLK_RST;
         guard_ff <= GUARD_RST;
      end else if (wr_take) begin
         case (avs_address)
            IDX_CTRL: ctrl_ff <= merge(ctrl_ff, avs_writedata, avs_byteenable) & CTRL_MASK;
            IDX_PLL: pll_ff <= merge(pll_ff, avs_writedata, avs_byteenable) & PLL_MASK;
            IDX_BANK: bank_ff <= merge(bank_ff, avs_writedata, avs_byteenable) & BANK_MASK;
            IDX_PCLK: pclk_ff <= merge(pclk_ff, avs_writedata, avs_byteenable) & PCLK_MASK;
            IDX_GUARD: guard_ff <= merge(guard_ff, avs_writedata, avs_byteenable) & GUARD_MASK;
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Reset sequencer
   // -----------------------------------------------------------------
   por_state_t st_ff, nxt_st;
   logic supplies_ok; // Power-up level reached on all watched rails
   logic trip;        // Brown-out seen in user mode
   logic standby_act; // Standby honoured only in user mode

   // Regulated parts also need the external rail
   assign supplies_ok = core_s && cfgbank_s && (ext_s || !HAS_REGULATOR);

   // Trips: bandgap level with bandgap, monitor and CTRL_MON_EN on; cell level with bandgap off; limited detector with monitor off
   always_comb begin
      trip = 1'b0;
      if (bandgap_en && por_monitor_en && ctrl_ff[CTRL_MON_EN] && !bg_ok_s) begin
         trip = 1'b1;
      end
      if (!bandgap_en && !cell_ok_s) begin
         trip = 1'b1;
      end
      if (!por_monitor_en && !limited_s) begin
         trip = 1'b1;
      end
      if (HAS_REGULATOR && !ext_s) begin
         trip = 1'b1;
      end
   end

   // Next state
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         POR_HOLD: nxt_st = POR_WAIT;
         POR_WAIT: begin
            if (supplies_ok) begin
               nxt_st = POR_LOAD;
            end
         end
         POR_LOAD: begin
            if (!supplies_ok) begin
               nxt_st = POR_WAIT;
            end else if (done_s) begin
               nxt_st = POR_USER;
            end
         end
         POR_USER: begin
            if (trip) begin
               nxt_st = POR_WAIT;
            end
         end
         default: nxt_st = POR_HOLD;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= POR_HOLD;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Sequencer outputs, registered from next state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         config_start <= 1'b0;
         io_tristate <= 1'b1;
         device_reset <= 1'b1;
      end else begin
         config_start <= (st_ff == POR_WAIT) && (nxt_st == POR_LOAD);
         io_tristate <= nxt_st != POR_USER;
         device_reset <= nxt_st != POR_USER;
      end
   end

   // -----------------------------------------------------------------
   // Power enables
   // -----------------------------------------------------------------
   logic bg_off;  // Bandgap shut for standby
   pll_pwr_if #(.N(NUM_PLL)) pif ();

   // Standby only outside reset sequencing; removal restores everything
   assign standby_act = standby_s && (st_ff == POR_USER);
   // Bandgap option ignored unless core is 1.2 V
   assign bg_off = standby_act && ctrl_ff[CTRL_BG_STBY] && CORE_1V2;

   // Analog enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bandgap_en <= 1'b1;
         por_monitor_en <= 1'b1;
         osc_en <= 1'b1;
      end else begin
         bandgap_en <= !bg_off;
         por_monitor_en <= !bg_off && !(standby_act && ctrl_ff[CTRL_POR_STBY]);
         osc_en <= !bg_off && !ctrl_ff[CTRL_OSC_OFF] && !(standby_act && ctrl_ff[CTRL_OSC_STBY]);
      end
   end

   // Limited detector never switched off
   assign limited_detect_en = 1'b1;
   // Threshold choice follows bandgap
   assign brownout_sel_bandgap = bandgap_en;

   // Per-PLL off requests
   for (genvar i = 0; i < NUM_PLL; i++) begin : g_pllreq
      assign pif.off_req[i] = pll_ff[i] || (standby_act && pll_ff[PLL_STBY_POS+i]) || bg_off;
   end
   assign pif.outs_low = pll_outs_low;
   assign pll_pwr_en = pif.pwr_en;
   assign pll_out_gate = pif.gate;

   pll_gate #(.N(NUM_PLL)) u_pll (
      .clk(clk),
      .rst(rst),
      .pif(pif)
   );

   // Bank buffers; absent banks stay off on small parts
   for (genvar b = 0; b < MAX_BANK; b++) begin : g_bank
      localparam bit PRESENT = b < (LARGE_DENSITY ? BANKS_LARGE : BANKS_SMALL);
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            bank_refdiff_en[b] <= 1'b0;
         end else begin
            bank_refdiff_en[b] <= PRESENT && !bank_ff[b] && !bg_off;
         end
      end
   end

   // Primary clock nets
   for (genvar c = 0; c < NUM_PCLK; c++) begin : g_pclk
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            pclk_en[c] <= 1'b1;
         end else begin
            pclk_en[c] <= !pclk_ff[c];
         end
      end
   end

   // Input buffer guard, static or standby
   for (genvar g = 0; g < NUM_INBUF; g++) begin : g_guard
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            inbuf_en[g] <= 1'b1;
         end else begin
            inbuf_en[g] <= !guard_ff[g] && !(standby_act && guard_ff[GUARD_STBY_POS+g]);
         end
      end
   end

   // Status word
   assign status = {8'h00, 8'(pll_pwr_en), 7'h00, supplies_ok, io_tristate, osc_en,
                    por_monitor_en, bandgap_en, standby_act, 1'b0, st_ff};

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_supplies_ready;
      st_ff == POR_WAIT && supplies_ok;
   endsequence
   sequence s_load_started;
      config_start && st_ff == POR_LOAD ##1 !config_start;
   endsequence

   property p_bg_forces;
      !bandgap_en |-> !por_monitor_en && !osc_en && bank_refdiff_en == '0;
   endproperty
   a_bg_forces: assert property (p_bg_forces)
      else $error("bandgap off left analog circuits on");

   property p_bg_variant;
      !CORE_1V2 |-> bandgap_en;
   endproperty
   a_bg_variant: assert property (p_bg_variant)
      else $error("bandgap shut on non 1.2 V variant");

   property p_osc_static;
      ctrl_ff[CTRL_OSC_OFF] ##1 ctrl_ff[CTRL_OSC_OFF] |-> !osc_en;
   endproperty
   a_osc_static: assert property (p_osc_static)
      else $error("oscillator on while statically disabled");

   property p_start;
      s_supplies_ready |=> s_load_started;
   endproperty
   a_start: assert property (p_start)
      else $error("download not started on supplies ready");

   property p_tristate;
      st_ff != POR_USER |-> io_tristate && device_reset;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("I/O released before configuration done");

   property p_brownout;
      st_ff == POR_USER && trip |=> st_ff == POR_WAIT && device_reset && io_tristate;
   endproperty
   a_brownout: assert property (p_brownout)
      else $error("brown-out did not return to monitoring");

   property p_sel;
      brownout_sel_bandgap == bandgap_en;
   endproperty
   a_sel: assert property (p_sel)
      else $error("threshold select does not follow bandgap");

   property p_bank_off;
      bank_ff[0] ##1 bank_ff[0] |-> !bank_refdiff_en[0];
   endproperty
   a_bank_off: assert property (p_bank_off)
      else $error("bank buffers on while disabled");

   property p_standby_release;
      $fell(standby_s) && st_ff == POR_USER && !ctrl_ff[CTRL_OSC_OFF] ##1 st_ff == POR_USER |-> osc_en;
   endproperty
   a_standby_release: assert property (p_standby_release)
      else $error("oscillator not restored after standby");
endmodule

/* File: design/sync2.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Two-flop synchroniser for pin-level inputs
// -----------------------------------------------------------------
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff; // Only read by q

   // First stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
      end else begin
         meta_ff <= d;
      end
   end

   // Second stage, safe to use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= meta_ff;
      end
   end
endmodule

/* File: sim/standby_power_and_por_control_tb.sv */
`timescale 1ns/1ps
module standby_power_and_por_control_tb;
   import pwr_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic standby_req = 1'b0;
   logic core_ok = 1'b0;
   logic bank_ok = 1'b0;
   logic ext_ok = 1'b1;
   logic bg_ok = 1'b1;
   logic cell_ok = 1'b1;
   logic lim_ok = 1'b1;
   logic config_done = 1'b0;
   logic [1:0] outs_low = 2'b00;
   logic [1:0] pll_pwr_en, pll_out_gate;
   logic bandgap_en, por_monitor_en, limited_detect_en, osc_en, brownout_sel_bandgap;
   logic [MAX_BANK-1:0] bank_refdiff_en;
   logic [7:0] pclk_en;
   logic [15:0] inbuf_en;
   logic io_tristate, config_start, device_reset;
   logic [31:0] rd;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_start = 0; // Download start pulses seen
   // ------------------------------------------------------------
   // Clock and device
   // ------------------------------------------------------------
   // 125 MHz clock
   always #4 clk = ~clk;
   standby_power_and_por_control u_standby_power_and_por_control (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .standby_req(standby_req), .core_supply_ok(core_ok),
      .config_bank_supply_ok(bank_ok), .ext_supply_ok(ext_ok), .brownout_bg_ok(bg_ok),
      .brownout_cell_ok(cell_ok), .limited_detect_ok(lim_ok), .config_done(config_done),
      .pll_outs_low(outs_low), .pll_pwr_en(pll_pwr_en), .pll_out_gate(pll_out_gate),
      .bandgap_en(bandgap_en), .por_monitor_en(por_monitor_en), .limited_detect_en(limited_detect_en),
      .osc_en(osc_en), .brownout_sel_bandgap(brownout_sel_bandgap), .bank_refdiff_en(bank_refdiff_en),
      .pclk_en(pclk_en), .inbuf_en(inbuf_en), .io_tristate(io_tristate), .config_start(config_start),
      .device_reset(device_reset));

   // Count download starts; each pulse stands one cycle
   always @(posedge clk) begin
      if (config_start) begin
         n_start <= n_start + 1;
      end
   end

   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   // Write; held until waitrequest seen low, then one idle edge
   task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= 4'hF;
      avs_write <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest) begin
         @(posedge clk);
      end
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   // Read; data taken at the edge where waitrequest is low
   task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest) begin
         @(posedge clk);
      end
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   // Compare; unknown bits count as a mismatch
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic results();
      $display("%0d compared, %0d mismatched", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   // Watchdog; the tests need about 130 cycles
   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      $display("watchdog expired");
      results();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      // Power-up: held until supplies, then download, then release
      check("held before supplies", 32'({io_tristate, device_reset, config_start}), 32'h0000_0006);
      bus_read(IDX_STATUS, rd);
      check("status waiting", rd, 32'h0003_00F1);
      bus_read(IDX_CTRL, rd);
      check("control reset", rd, CTRL_RST);
      core_ok <= 1'b1;
      bank_ok <= 1'b1;
      repeat (8) @(posedge clk);
      check("download started", 32'(n_start), 32'h0000_0001);
      check("held during load", 32'({io_tristate, device_reset}), 32'h0000_0003);
      config_done <= 1'b1;
      repeat (5) @(posedge clk);
      check("released to user", 32'({io_tristate, device_reset}), 32'h0000_0000);
      $display("power-up test done");
      // Registers: clock nets, banks, oscillator static off
      bus_write(IDX_PCLK, 32'h0000_00A5);
      bus_read(IDX_PCLK, rd);
      check("clock net register", rd, 32'h0000_00A5);
      check("clock net enables", 32'(pclk_en), 32'h0000_005A);
      bus_write(IDX_BANK, 32'hFFFF_FFC1);
      bus_read(IDX_BANK, rd);
      check("bank register", rd, 32'h0000_0001);
      check("bank 0 off", 32'(bank_refdiff_en), 32'h0000_003E);
      bus_write(IDX_BANK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check("six banks on", 32'(bank_refdiff_en), 32'h0000_003F);
      bus_write(IDX_CTRL, 32'hFFFF_FFE4);
      bus_read(IDX_CTRL, rd);
      check("control register", rd, 32'h0000_0004);
      check("oscillator static off", 32'(osc_en), 32'h0000_0000);
      $display("register test done");
      // PLL: outputs gated first, power drops once outputs low
      bus_write(IDX_PLL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      check("pll gated, powered", 32'({pll_out_gate, pll_pwr_en}), 32'h0000_0007);
      outs_low <= 2'b01;
      repeat (5) @(posedge clk);
      check("pll powered off", 32'({pll_out_gate, pll_pwr_en}), 32'h0000_0006);
      outs_low <= 2'b00;
      bus_write(IDX_PLL, 32'h0000_0000);
      repeat (4) @(posedge clk);
      check("pll back on", 32'({pll_out_gate, pll_pwr_en}), 32'h0000_0003);
      $display("pll test done");
      // Standby with bandgap shutdown, then removal
      bus_write(IDX_CTRL, CTRL_RST | (32'h0000_0001 << CTRL_BG_STBY) | (32'h0000_0001 << CTRL_OSC_STBY));
      bus_write(IDX_GUARD, 32'h0001_0002);
      bus_write(IDX_PLL, 32'h0000_0200);
      repeat (2) @(posedge clk);
      check("guard static", 32'(inbuf_en), 32'h0000_FFFD);
      standby_req <= 1'b1;
      repeat (5) @(posedge clk);
      check("standby analog off", 32'({bandgap_en, por_monitor_en, osc_en, bank_refdiff_en}), 32'h0000_0000);
      check("cell level, detector on", 32'({brownout_sel_bandgap, limited_detect_en}), 32'h0000_0001);
      check("guard standby", 32'(inbuf_en), 32'h0000_FFFC);
      check("standby pll gated", 32'({pll_out_gate, pll_pwr_en}), 32'h0000_000F);
      standby_req <= 1'b0;
      repeat (6) @(posedge clk);
      check("standby restored", 32'({bandgap_en, por_monitor_en, osc_en, bank_refdiff_en}), 32'h0000_01FF);
      check("standby guard restored", 32'(inbuf_en), 32'h0000_FFFD);
      check("standby pll restored", 32'({pll_out_gate, pll_pwr_en}), 32'h0000_0003);
      $display("standby test done");
      // Brown-out with bandgap and monitor kept on while supply sags
      config_done <= 1'b0;
      bg_ok <= 1'b0;
      repeat (6) @(posedge clk);
      check("brown-out reset", 32'({io_tristate, device_reset, brownout_sel_bandgap}), 32'h0000_0007);
      check("download again", 32'(n_start), 32'h0000_0002);
      bg_ok <= 1'b1;
      config_done <= 1'b1;
      repeat (5) @(posedge clk);
      check("user again", 32'({io_tristate, device_reset}), 32'h0000_0000);
      // Low-power cell monitor while the bandgap is off
      standby_req <= 1'b1;
      repeat (5) @(posedge clk);
      config_done <= 1'b0;
      cell_ok <= 1'b0;
      repeat (6) @(posedge clk);
      check("cell monitor reset", 32'({io_tristate, device_reset, bandgap_en}), 32'h0000_0007);
      check("download third", 32'(n_start), 32'h0000_0003);
      standby_req <= 1'b0;
      cell_ok <= 1'b1;
      config_done <= 1'b1;
      repeat (5) @(posedge clk);
      check("user after cell trip", 32'({io_tristate, device_reset}), 32'h0000_0000);
      $display("brown-out test done");
      results();
   end
endmodule
